// *** rtl/tscr_delay_mem.sv ***
// Small dual-port store used as the transmit data delay line.
// Assumes one write and one read each cycle; read data are registered.
`timescale 1ns/100ps
module tscr_delay_mem #(
    parameter int W  = 5,
    parameter int AW = 8
) (
    input  wire logic          clk,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [W-1:0]  wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [W-1:0]  rdata
);

    logic [W-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk)
    begin
        mem[waddr] <= wdata;
        rdata      <= mem[raddr];
    end

endmodule

// *** rtl/tscr_pkg.sv ***
// Constants for the tile status and control register bank.
// Assumes a single core clock that also stands for the PLL output.
package tscr_pkg;

    // Register numbers, as used in processor-status accesses
    localparam logic [7:0]  REG_TILE_CTRL    = 8'h02;
    localparam logic [7:0]  REG_BOOT_STATUS  = 8'h03;
    localparam logic [7:0]  REG_SECURITY     = 8'h05;
    localparam logic [7:0]  REG_RO_CTRL      = 8'h06;

    // Tile control fields
    localparam int          TC_DELAY_LSB     = 18;
    localparam int          TC_DELAY_W       = 8;
    localparam int          TC_DIV_LSB       = 9;
    localparam int          TC_DIV_W         = 9;
    localparam int          TC_RGMII_EN      = 8;
    localparam int          TC_LP_DYN        = 5;
    localparam int          TC_LP_EN         = 4;
    localparam int          TC_UTMI_SEL      = 2;
    localparam int          TC_ULPI_HW       = 1;
    localparam logic [31:0] TC_WMASK         = 32'h03ff_ff36;
    localparam logic [31:0] TC_RESET         = 32'h0000_0000;

    // Boot status fields
    localparam int          BS_PROC_LSB      = 16;
    localparam int          BS_BOOT_OVR      = 8;
    localparam int          BS_CORE1_OFF     = 5;
    localparam int          BS_SKIP_POLL     = 4;
    localparam int          BS_FROM_RAM      = 3;
    localparam int          BS_FROM_JTAG     = 2;
    localparam int          BS_PLL_LSB       = 0;
    localparam logic [31:0] BS_RESET         = 32'h0000_0000;

    // Security configuration fields
    localparam int          SEC_WLOCK        = 31;
    localparam int          SEC_DBG_DIS      = 14;
    localparam int          SEC_LOCK_ALL     = 12;
    localparam int          SEC_SECT_LSB     = 8;
    localparam int          SEC_REDUND       = 7;
    localparam int          SEC_BOOT_OTP     = 5;
    localparam int          SEC_JTAG_CFG_DIS = 4;
    localparam int          SEC_TAP_DIS      = 0;
    localparam logic [31:0] SEC_WMASK        = 32'h8000_5fb1;
    localparam logic [31:0] SEC_RESET        = 32'h0000_0000;

    // Ring oscillator control fields
    localparam int          RO_PERIPH_EN     = 0;
    localparam int          RO_CORE_EN       = 1;
    localparam logic [31:0] RO_WMASK         = 32'h0000_0003;
    localparam logic [31:0] RO_RESET         = 32'h0000_0000;
    localparam int          RO_COUNT_W       = 16;
    localparam int          RO_NUM           = 4;

    // Low-power divide ratio, in core cycles
    localparam logic [3:0]  LP_DIV_CYCLES    = 4'h4;

    // Transmit path: 4 data bits plus control, 256-deep delay store
    localparam int          TXD_W            = 5;
    localparam int          DLY_AW           = 8;

endpackage

// *** rtl/tscr_ro_counter.sv ***
// One ring oscillator counter with its crossing into the core clock.
// Assumes the oscillator output is a free-running level toggle.
`timescale 1ns/100ps
module tscr_ro_counter #(
    parameter int CW = 16
) (
    input  wire logic          clk,
    input  wire logic          run,
    input  wire logic          osc,
    output logic      [CW-1:0] count
);

    logic          sync_a;
    logic          sync_b;
    logic          sync_c;
    // Power-up value only; srst never clears it
    logic [CW-1:0] tally = '0;
    wire           osc_edge = sync_b ^ sync_c;

    assign count = tally;

    // No reset: counts survive a system reset
    always_ff @(posedge clk)
    begin
        sync_a <= osc;
        sync_b <= sync_a;
        sync_c <= sync_b;
        if (run && osc_edge)
        begin
            tally <= tally + 1'b1;
        end
    end

endmodule

// *** rtl/tscr_tile_regs.sv ***
// Tile status and control register bank with its dependent logic.
// Assumes clk is both core clock and PLL output; pins are synchronous.
`timescale 1ns/100ps
module tscr_tile_regs (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        ps_wr,
    input  wire logic        ps_rd,
    input  wire logic [7:0]  ps_num,
    input  wire logic [31:0] ps_wdata,
    output logic      [31:0] ps_rdata,
    output logic             ps_rvalid,
    input  wire logic        otp_sec_load,
    input  wire logic [31:0] otp_sec_word,
    input  wire logic [7:0]  proc_number,
    input  wire logic        boot_mode_overridden,
    input  wire logic        core1_powered_off,
    input  wire logic        skip_otp_level_poll,
    input  wire logic        boot_from_ram,
    input  wire logic        boot_from_jtag,
    input  wire logic [1:0]  boot_pll_mode,
    input  wire logic        all_threads_paused,
    input  wire logic [4:0]  tx_data_in,
    output logic      [4:0]  rgmii_txd_out,
    output logic             rgmii_txclk,
    output logic             rgmii_ports_en,
    output logic             core_clk_en,
    output logic             utmi_mode,
    output logic             ulpi_assist_en,
    output logic             debug_global_off,
    output logic             jtag_tap_off,
    output logic             otp_lock_all,
    output logic      [3:0]  otp_sector_lock,
    output logic             otp_redundancy_en,
    output logic             boot_force_otp,
    output logic             jtag_cfg_block,
    input  wire logic [3:0]  ro_osc,
    output logic      [15:0] ro_count0,
    output logic      [15:0] ro_count1,
    output logic      [15:0] ro_count2,
    output logic      [15:0] ro_count3
);

    // Register state
    logic [31:0] tile_control;
    logic [31:0] boot_status;
    logic [31:0] security;
    logic [31:0] ro_control;
    logic [1:0]  pll_mode_held;
    logic        pll_mode_taken;

    // Register decode
    wire hit_tc  = (ps_num == tscr_pkg::REG_TILE_CTRL);
    wire hit_bs  = (ps_num == tscr_pkg::REG_BOOT_STATUS);
    wire hit_sec = (ps_num == tscr_pkg::REG_SECURITY);
    wire hit_ro  = (ps_num == tscr_pkg::REG_RO_CTRL);

    wire wr_tc   = ps_wr && hit_tc;
    wire wr_sec  = ps_wr && hit_sec
                   && !security[tscr_pkg::SEC_WLOCK];
    wire wr_ro   = ps_wr && hit_ro;

    // Reserved bits stay zero since only masked bits change
    wire [31:0] next_tile_control =
        ps_wdata & tscr_pkg::TC_WMASK;
    wire [31:0] next_security =
        ps_wdata & tscr_pkg::SEC_WMASK;
    wire [31:0] next_ro_control =
        ps_wdata & tscr_pkg::RO_WMASK;
    wire [31:0] otp_security =
        otp_sec_word & tscr_pkg::SEC_WMASK;

    // Field views of tile control
    wire [7:0] tx_delay =
        tile_control[tscr_pkg::TC_DELAY_LSB +: tscr_pkg::TC_DELAY_W];
    wire [8:0] tx_div =
        tile_control[tscr_pkg::TC_DIV_LSB +: tscr_pkg::TC_DIV_W];
    wire       lp_en  = tile_control[tscr_pkg::TC_LP_EN];
    wire       lp_dyn = tile_control[tscr_pkg::TC_LP_DYN];

    // Read data select; unmapped numbers read zero
    wire [31:0] rd_sel =
        hit_tc  ? tile_control :
        hit_bs  ? boot_status  :
        hit_sec ? security     :
        hit_ro  ? ro_control   :
        32'h0000_0000;

    // Tile control register
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            tile_control <= tscr_pkg::TC_RESET;
        end
        else if (wr_tc)
        begin
            tile_control <= next_tile_control;
        end
    end

    // Security configuration; an OTP load overrides the lock
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            security <= tscr_pkg::SEC_RESET;
        end
        else if (otp_sec_load)
        begin
            security <= otp_security;
        end
        else if (wr_sec)
        begin
            security <= next_security;
        end
    end

    // Ring oscillator control
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ro_control <= tscr_pkg::RO_RESET;
        end
        else if (wr_ro)
        begin
            ro_control <= next_ro_control;
        end
    end

    // PLL mode pins are caught once, the first cycle after reset
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pll_mode_taken <= 1'b0;
            pll_mode_held  <= 2'h0;
        end
        else if (!pll_mode_taken)
        begin
            pll_mode_taken <= 1'b1;
            pll_mode_held  <= boot_pll_mode;
        end
    end

    // Boot status mirrors its inputs, the PLL mode from the held copy; nothing writes it
    wire [31:0] next_boot_status =
        ({24'h00_0000, proc_number} << tscr_pkg::BS_PROC_LSB)
        | ({31'h0000_0000, boot_mode_overridden}
            << tscr_pkg::BS_BOOT_OVR)
        | ({31'h0000_0000, core1_powered_off}
            << tscr_pkg::BS_CORE1_OFF)
        | ({31'h0000_0000, skip_otp_level_poll}
            << tscr_pkg::BS_SKIP_POLL)
        | ({31'h0000_0000, boot_from_ram}
            << tscr_pkg::BS_FROM_RAM)
        | ({31'h0000_0000, boot_from_jtag}
            << tscr_pkg::BS_FROM_JTAG)
        | ({30'h0000_0000, pll_mode_held}
            << tscr_pkg::BS_PLL_LSB);

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            boot_status <= tscr_pkg::BS_RESET;
        end
        else
        begin
            boot_status <= next_boot_status;
        end
    end

    // Read port: data one cycle after the request
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ps_rdata  <= 32'h0000_0000;
            ps_rvalid <= 1'b0;
        end
        else
        begin
            ps_rvalid <= ps_rd;
            if (ps_rd)
            begin
                ps_rdata <= rd_sel;
            end
        end
    end

    // Control outputs straight from the register flops
    assign rgmii_ports_en    = tile_control[tscr_pkg::TC_RGMII_EN];
    assign utmi_mode         = tile_control[tscr_pkg::TC_UTMI_SEL];
    assign ulpi_assist_en    = tile_control[tscr_pkg::TC_ULPI_HW];
    assign debug_global_off  = security[tscr_pkg::SEC_DBG_DIS];
    assign jtag_tap_off      = security[tscr_pkg::SEC_TAP_DIS];
    assign otp_lock_all      = security[tscr_pkg::SEC_LOCK_ALL];
    assign otp_sector_lock   = security[tscr_pkg::SEC_SECT_LSB +: 4];
    assign otp_redundancy_en = security[tscr_pkg::SEC_REDUND];
    assign boot_force_otp    = security[tscr_pkg::SEC_BOOT_OTP];
    assign jtag_cfg_block    = security[tscr_pkg::SEC_JTAG_CFG_DIS];

    // Low-power divider: enable pulse once per LP_DIV_CYCLES
    logic [3:0] lp_cnt;
    wire        lp_dividing = lp_en
                              && (!lp_dyn || all_threads_paused);
    wire        lp_wrap     = (lp_cnt == (tscr_pkg::LP_DIV_CYCLES - 4'h1));

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            lp_cnt      <= 4'h0;
            core_clk_en <= 1'b1;
        end
        else if (lp_dividing)
        begin
            lp_cnt      <= lp_wrap ? 4'h0 : lp_cnt + 4'h1;
            core_clk_en <= (lp_cnt == 4'h0);
        end
        else
        begin
            lp_cnt      <= 4'h0;
            core_clk_en <= 1'b1;
        end
    end

    // Transmit clock: high at the divider value, low at half of it
    logic [8:0] tx_cnt;
    wire        tx_at_top  = (tx_cnt >= tx_div);
    wire [8:0]  tx_half    = tx_div >> 1;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            tx_cnt      <= 9'h000;
            rgmii_txclk <= 1'b0;
        end
        else
        begin
            // Counter restarts if the divider shrinks below it
            tx_cnt <= tx_at_top ? 9'h000 : tx_cnt + 9'h001;
            if (tx_cnt == tx_div)
            begin
                rgmii_txclk <= 1'b1;
            end
            else if (tx_cnt == tx_half)
            begin
                rgmii_txclk <= 1'b0;
            end
        end
    end

    // Transmit data delay line; total latency is delay plus one
    logic [7:0] dly_wptr;
    logic [4:0] tx_d1;
    logic [4:0] dly_rdata;
    wire  [7:0] dly_raddr = dly_wptr - tx_delay + 8'h01;

    // Short delays bypass the store, whose read lags by two
    wire  [4:0] next_txd =
        (tx_delay == 8'h00) ? tx_data_in :
        (tx_delay == 8'h01) ? tx_d1      :
        dly_rdata;

    tscr_delay_mem #(
        .W  (tscr_pkg::TXD_W),
        .AW (tscr_pkg::DLY_AW)
    ) u_delay (
        .clk   (clk),
        .waddr (dly_wptr),
        .wdata (tx_data_in),
        .raddr (dly_raddr),
        .rdata (dly_rdata)
    );

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            dly_wptr      <= 8'h00;
            tx_d1         <= 5'h00;
            rgmii_txd_out <= 5'h00;
        end
        else
        begin
            dly_wptr      <= dly_wptr + 8'h01;
            tx_d1         <= tx_data_in;
            rgmii_txd_out <= next_txd;
        end
    end

    // Ring oscillator counters: 0,1 core pair; 2,3 peripheral pair
    wire core_run   = ro_control[tscr_pkg::RO_CORE_EN];
    wire periph_run = ro_control[tscr_pkg::RO_PERIPH_EN];

    tscr_ro_counter #(
        .CW (tscr_pkg::RO_COUNT_W)
    ) u_ro0 (
        .clk   (clk),
        .run   (core_run),
        .osc   (ro_osc[0]),
        .count (ro_count0)
    );

    tscr_ro_counter #(
        .CW (tscr_pkg::RO_COUNT_W)
    ) u_ro1 (
        .clk   (clk),
        .run   (core_run),
        .osc   (ro_osc[1]),
        .count (ro_count1)
    );

    tscr_ro_counter #(
        .CW (tscr_pkg::RO_COUNT_W)
    ) u_ro2 (
        .clk   (clk),
        .run   (periph_run),
        .osc   (ro_osc[2]),
        .count (ro_count2)
    );

    tscr_ro_counter #(
        .CW (tscr_pkg::RO_COUNT_W)
    ) u_ro3 (
        .clk   (clk),
        .run   (periph_run),
        .osc   (ro_osc[3]),
        .count (ro_count3)
    );

    // Counters settle on the edge that clears their enable, since run gates the count
    // after the synchroniser; the bench still waits twelve cycles before sampling.

endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the tile register bank.
// Assumes reads answer one cycle after the strobe; inputs change at falling edges.
`timescale 1ns/100ps
module testbench;
    typedef struct packed {logic [7:0] num; logic [31:0] wdata; logic [31:0] exp;} tscr_row_type;
    logic         clk, srst, ps_wr, ps_rd, ps_rvalid, otp_sec_load, osc_run;
    logic         boot_mode_overridden, core1_powered_off, skip_otp_level_poll, boot_from_ram;
    logic         boot_from_jtag, all_threads_paused, rgmii_txclk, rgmii_ports_en, core_clk_en;
    logic         utmi_mode, ulpi_assist_en, debug_global_off, jtag_tap_off, otp_lock_all;
    logic         otp_redundancy_en, boot_force_otp, jtag_cfg_block;
    logic [1:0]   boot_pll_mode;
    logic [3:0]   otp_sector_lock, ro_osc;
    logic [4:0]   tx_data_in, rgmii_txd_out;
    logic [7:0]   ps_num, proc_number;
    logic [15:0]  ro_count0, ro_count1, ro_count2, ro_count3;
    logic [31:0]  ps_wdata, ps_rdata, otp_sec_word, got, e;
    logic [63:0]  snap;
    wire  [9:0]   sec_outs = {debug_global_off, otp_lock_all, otp_sector_lock, otp_redundancy_en,
                              boot_force_otp, jtag_cfg_block, jtag_tap_off};
    int           n_fail, compares, hi;
    logic [7:0]   dly [3] = '{8'h00, 8'h03, 8'hff};
    int           dv [3] = '{0, 4, 9};
    tscr_row_type rows [10] = '{'{8'h02, 32'hffff_ffff, tscr_pkg::TC_WMASK},
        '{8'h02, 32'h5555_5555, 32'h5555_5555 & tscr_pkg::TC_WMASK}, '{8'h02, 32'h0, 32'h0},
        '{8'h06, 32'hffff_ffff, tscr_pkg::RO_WMASK}, '{8'h06, 32'h0, 32'h0},
        '{8'h05, 32'h7fff_ffff, 32'h7fff_ffff & tscr_pkg::SEC_WMASK}, '{8'h05, 32'h0, 32'h0},
        '{8'h00, 32'hffff_ffff, 32'h0}, '{8'h07, 32'hffff_ffff, 32'h0}, '{8'hff, 32'hffff_ffff, 32'h0}};

    tscr_tile_regs tscr_tile_regs_i (.clk, .srst, .ps_wr, .ps_rd, .ps_num, .ps_wdata, .ps_rdata, .ps_rvalid,
        .otp_sec_load, .otp_sec_word, .proc_number, .boot_mode_overridden, .core1_powered_off,
        .skip_otp_level_poll, .boot_from_ram, .boot_from_jtag, .boot_pll_mode, .all_threads_paused,
        .tx_data_in, .rgmii_txd_out, .rgmii_txclk, .rgmii_ports_en, .core_clk_en, .utmi_mode,
        .ulpi_assist_en, .debug_global_off, .jtag_tap_off, .otp_lock_all, .otp_sector_lock,
        .otp_redundancy_en, .boot_force_otp, .jtag_cfg_block, .ro_osc, .ro_count0, .ro_count1,
        .ro_count2, .ro_count3);

    function automatic logic [9:0] secx(input logic [31:0] w);
        return {w[14], w[12], w[11:8], w[7], w[5], w[4], w[0]};
    endfunction
    task automatic check(input logic [31:0] g, input logic [31:0] x);
        compares++;
        if (g !== x)
        begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, g, x);
        end
    endtask
    task automatic wr(input logic [7:0] n, input logic [31:0] d);
        @(negedge clk);
        ps_wr = 1'b1;
        ps_num = n;
        ps_wdata = d;
        @(negedge clk);
        ps_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] n);
        @(negedge clk);
        ps_rd = 1'b1;
        ps_num = n;
        @(negedge clk);
        ps_rd = 1'b0;
        check({31'h0, ps_rvalid}, 32'h1);
        got = ps_rdata;
    endtask
    task automatic otp_load(input logic [31:0] w);
        @(negedge clk);
        otp_sec_word = w;
        otp_sec_load = 1'b1;
        @(negedge clk);
        otp_sec_load = 1'b0;
    endtask
    // Counts whole periods only, so the phase at the start does not matter
    task automatic count_hi(input bit sel, input int n);
        hi = 0;
        repeat (n)
        begin
            @(negedge clk);
            hi += sel ? (core_clk_en === 1'b1) : (rgmii_txclk === 1'b1);
        end
    endtask
    task automatic lp_chk(input int n);
        repeat (8) @(negedge clk);
        count_hi(1'b1, 40);
        check(hi, n);
    endtask
    task automatic complete_run;
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(negedge clk) tx_data_in <= tx_data_in + 5'h1;
    always @(negedge clk) if (osc_run) ro_osc <= ~ro_osc;
    initial
    begin
        #(100 * 20000);
        n_fail++;
        complete_run;
    end

    initial
    begin
        {ps_wr, ps_rd, otp_sec_load, all_threads_paused, osc_run, srst} = 6'h01;
        {ps_num, ps_wdata, otp_sec_word, tx_data_in, ro_osc} = '0;
        {n_fail, compares} = '0;
        {proc_number, boot_pll_mode} = {8'h5a, 2'b10};
        {boot_mode_overridden, core1_powered_off, skip_otp_level_poll, boot_from_ram, boot_from_jtag} = 5'h16;
        repeat (10) @(negedge clk);
        srst = 1'b0;
        repeat (2) @(negedge clk);
        boot_pll_mode = 2'b01;
        foreach (rows[i])
        begin
            rd(rows[i].num);
            check(got, 32'h0);
        end
        check({30'h0, core_clk_en, rgmii_txclk}, 32'h3);
        $display("test reset done");
        foreach (rows[i])
        begin
            e = rows[i].exp;
            wr(rows[i].num, rows[i].wdata);
            rd(rows[i].num);
            check(got, e);
            if (rows[i].num == 8'h02)
                check({29'h0, rgmii_ports_en, utmi_mode, ulpi_assist_en}, {29'h0, e[8], e[2], e[1]});
            if (rows[i].num == 8'h05)
                check({22'h0, sec_outs}, {22'h0, secx(e)});
        end
        $display("test table done");
        wr(8'h03, 32'hffff_ffff);
        rd(8'h03);
        check(got, 32'h005a_011a);
        {proc_number, boot_mode_overridden, core1_powered_off, skip_otp_level_poll, boot_from_ram, boot_from_jtag} = 13'h14a9;
        repeat (2) @(negedge clk);
        rd(8'h03);
        check(got, 32'h00a5_0026);
        $display("test boot done");
        foreach (dly[i])
        begin
            wr(8'h02, {6'h0, dly[i], 18'h0});
            repeat (260) @(negedge clk);
            repeat (4)
            begin
                @(posedge clk);
                #1;
                check({27'h0, rgmii_txd_out}, {27'h0, tx_data_in - dly[i][4:0]});
            end
        end
        $display("test delay done");
        foreach (dv[i])
        begin
            wr(8'h02, 32'(dv[i]) << 9);
            repeat (20) @(negedge clk);
            count_hi(1'b0, 4 * (dv[i] + 1));
            check(hi, 4 * ((dv[i] >> 1) + 1));
        end
        $display("test tx clock done");
        wr(8'h02, 32'h0000_0010);
        lp_chk(10);
        wr(8'h02, 32'h0000_0030);
        lp_chk(40);
        all_threads_paused = 1'b1;
        lp_chk(10);
        wr(8'h02, 32'h0);
        $display("test low power done");
        otp_load(32'hffff_ffff);
        rd(8'h05);
        check(got, tscr_pkg::SEC_WMASK);
        check({22'h0, sec_outs}, 32'h0000_03ff);
        wr(8'h05, 32'h0);
        rd(8'h05);
        check(got, tscr_pkg::SEC_WMASK);
        otp_load(32'h0);
        wr(8'h05, 32'h8000_0011);
        wr(8'h05, 32'h0);
        rd(8'h05);
        check(got, 32'h8000_0011);
        $display("test security done");
        @(negedge clk);
        {ps_wr, ps_rd, ps_num, ps_wdata} = {2'b11, 8'h02, 32'h0000_0106};
        @(negedge clk);
        {ps_wr, ps_rd} = 2'b00;
        check(ps_rdata, 32'h0);
        rd(8'h02);
        check(got, 32'h0000_0106);
        $display("test same cycle done");
        wr(8'h06, 32'h0000_0003);
        osc_run = 1'b1;
        repeat (20) @(negedge clk);
        wr(8'h06, 32'h0);
        repeat (12) @(negedge clk);
        snap = {ro_count3, ro_count2, ro_count1, ro_count0};
        check({31'h0, snap[15:0] != 16'h0000}, 32'h1);
        check(snap[31:0], snap[63:32]);
        repeat (20) @(negedge clk);
        check(snap[31:0], {ro_count1, ro_count0});
        // Second reset mid-run: counters 2 and 3 must survive, pll pins resampled
        srst = 1'b1;
        repeat (3) @(negedge clk);
        srst = 1'b0;
        check(snap[63:32], {ro_count3, ro_count2});
        repeat (2) @(negedge clk);
        rd(8'h03);
        check(got, 32'h00a5_0025);
        rd(8'h06);
        check(got, 32'h0);
        snap = {ro_count3, ro_count2, ro_count1, ro_count0};
        wr(8'h06, 32'h0000_0001);
        repeat (20) @(negedge clk);
        wr(8'h06, 32'h0);
        repeat (12) @(negedge clk);
        check({ro_count1, ro_count0}, snap[31:0]);
        check({31'h0, ro_count2 != snap[47:32]}, 32'h1);
        $display("test oscillator done");
        complete_run;
    end
endmodule

// *** tb/tscr_tile_regs_sva.sv ***
// Port checker for the tile register bank.
// Assumes one core clock and the bank's synchronous reset.
`timescale 1ns/100ps
module tscr_tile_regs_sva (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        ps_wr,
    input  wire logic        ps_rd,
    input  wire logic [7:0]  ps_num,
    input  wire logic [31:0] ps_wdata,
    input  wire logic [31:0] ps_rdata,
    input  wire logic        ps_rvalid,
    input  wire logic        otp_sec_load,
    input  wire logic [31:0] otp_sec_word,
    input  wire logic [7:0]  proc_number,
    input  wire logic        core_clk_en,
    input  wire logic        rgmii_txclk,
    input  wire logic        rgmii_ports_en,
    input  wire logic        utmi_mode,
    input  wire logic        ulpi_assist_en,
    input  wire logic        debug_global_off,
    input  wire logic        jtag_tap_off,
    input  wire logic        otp_lock_all,
    input  wire logic [3:0]  otp_sector_lock,
    input  wire logic        otp_redundancy_en,
    input  wire logic        boot_force_otp,
    input  wire logic        jtag_cfg_block
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    wire logic [9:0] sec_outs;
    assign sec_outs = {debug_global_off, otp_lock_all, otp_sector_lock, otp_redundancy_en,
                       boot_force_otp, jtag_cfg_block, jtag_tap_off};
    wire logic [9:0] otp_bits;
    assign otp_bits = {otp_sec_word[14], otp_sec_word[12], otp_sec_word[11:8], otp_sec_word[7],
                       otp_sec_word[5], otp_sec_word[4], otp_sec_word[0]};
    chk_read_answer: assert property (ps_rd |=> ps_rvalid)
        else $error("read strobe got no answer");
    chk_read_quiet: assert property (!ps_rd |=> !ps_rvalid)
        else $error("answer without read strobe");
    chk_unmapped_zero: assert property (ps_rd && !(ps_num inside {8'h02, 8'h03, 8'h05, 8'h06}) |=> ps_rdata == 32'h0)
        else $error("unmapped read not zero");
    // Boot bits lag the pins by one cycle, so the read shows them two back
    chk_boot_proc: assert property (ps_rd && ps_num == 8'h03 && !$past(srst) |=> ps_rdata[31:16] == {8'h00, $past(proc_number, 2)})
        else $error("processor number wrong");
    chk_reset_state: assert property ($fell(srst) |-> core_clk_en && !rgmii_txclk && !rgmii_ports_en && ps_rdata == 32'h0)
        else $error("state after reset wrong");
    chk_lp_gap: assert property (!core_clk_en |-> ##[1:3] core_clk_en)
        else $error("core enable gap too long");
    chk_ctrl_write: assert property ((ps_wr && ps_num == 8'h02) ##1 !ps_wr [*2] |-> {rgmii_ports_en, utmi_mode, ulpi_assist_en} == {$past(ps_wdata[8], 2), $past(ps_wdata[2], 2), $past(ps_wdata[1], 2)})
        else $error("control outputs do not follow write");
    chk_sec_lock: assert property ((ps_wr && ps_num == 8'h05 && ps_wdata[31] && !otp_sec_load) ##1 !otp_sec_load [*4] |-> sec_outs == $past(sec_outs, 3))
        else $error("locked security changed");
    chk_otp_copy: assert property (otp_sec_load ##1 (!otp_sec_load && !ps_wr) [*2] |-> sec_outs == $past(otp_bits, 2))
        else $error("security outputs differ from loaded word");
    cover property (ps_rd && ps_num == 8'h03);
    cover property (otp_sec_load ##1 ps_wr && ps_num == 8'h05);
    cover property (!core_clk_en ##1 core_clk_en);
endmodule

bind tscr_tile_regs tscr_tile_regs_sva tscr_tile_regs_sva_i (.clk, .srst, .ps_wr, .ps_rd, .ps_num, .ps_wdata,
    .ps_rdata, .ps_rvalid, .otp_sec_load, .otp_sec_word, .proc_number, .core_clk_en, .rgmii_txclk,
    .rgmii_ports_en, .utmi_mode, .ulpi_assist_en, .debug_global_off, .jtag_tap_off, .otp_lock_all,
    .otp_sector_lock, .otp_redundancy_en, .boot_force_otp, .jtag_cfg_block);
